/* logic/rsb_consts.svh */
/*
 * Register indices, field positions, reset values and timing counts
 * of the receive signaling buffer.
 * Assumes a 125 MHz clock; included by bare name.
 */
`ifndef RSB_CONSTS_SVH
`define RSB_CONSTS_SVH

// word indices; byte address is four times the index
`define RSB_IDX_CFG 10'h040
`define RSB_IDX_STAT 10'h041
`define RSB_IDX_ADDR 10'h042
`define RSB_IDX_DATA 10'h043
`define RSB_IDX_ISTS 10'h048
`define RSB_IDX_IEN 10'h049
`define RSB_IDX_ICLR 10'h04a

`define RSB_CFG_VIEW 6
`define RSB_CFG_SIGNAL_CHANGE_IRQ_EN 5
`define RSB_CFG_ESF 2
`define RSB_CFG_PER_CHANNEL_ENABLE 0
`define RSB_BUSY_BIT 7
`define RSB_RNW_BIT 7
`define RSB_CFG_MASK 8'h65
`define RSB_CFG_RST 8'h00
`define RSB_ADDR_RST 8'h00
`define RSB_DATA_RST 8'h00

// indirect space
`define RSB_LIVE_LO 7'h01
`define RSB_LIVE_HI 7'h18
`define RSB_LAG_LO 7'h21
`define RSB_LAG_HI 7'h38
`define RSB_DEB_LO 7'h41
`define RSB_DEB_HI 7'h58
`define RSB_NCHAN 24

// timing
`define RSB_CLK_NS 8
`define RSB_BUSY_NS 650
`define RSB_RDATA_NS 640
`define RSB_LAG_NS 2000000
`define RSB_BUSY_CYC ((`RSB_BUSY_NS + `RSB_CLK_NS - 1) / `RSB_CLK_NS)
`define RSB_RDATA_CYC (`RSB_RDATA_NS / `RSB_CLK_NS)
`define RSB_LAG_CYC (`RSB_LAG_NS / `RSB_CLK_NS)

`endif

/* logic/rsb_pkg.sv */
/*
 * Types shared by the receive signaling buffer modules.
 * Assumes nothing of its surroundings.
 */
package rsb_pkg;
    typedef logic [3:0] rsb_abcd_type;
    typedef logic [4:0] rsb_chan_type;
    typedef logic [23:0] rsb_flags_type;
    typedef enum logic {ind_idle, ind_run} rsb_ind_state_type;
endpackage : rsb_pkg

/* logic/rsb_chan_store.sv */
/*
 * Per-channel signaling store: live and lagged banks, debounce
 * settings and change flags for 24 channels.
 * Assumes sig_chan_i below 24 when sig_valid_i is high.
 */
`timescale 1ns/100ps
`include "rsb_consts.svh"

module rsb_chan_store (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic sig_valid_i,
    input wire rsb_pkg::rsb_chan_type sig_chan_i,
    input wire rsb_pkg::rsb_abcd_type sig_abcd_i,
    input wire logic esf_i,
    input wire logic per_channel_enable_i,
    input wire logic lag_tick_i,
    input wire logic cfg_we_i,
    input wire rsb_pkg::rsb_chan_type cfg_chan_i,
    input wire logic cfg_deb_i,
    input wire logic clr_en_i,
    input wire rsb_pkg::rsb_flags_type clr_mask_i,
    input wire rsb_pkg::rsb_chan_type rd_chan_i,
    output rsb_pkg::rsb_flags_type flags_o,
    output logic change_o,
    output rsb_pkg::rsb_abcd_type rd_live_o,
    output rsb_pkg::rsb_abcd_type rd_lag_o,
    output logic rd_deb_o
);
    import rsb_pkg::*;

    rsb_abcd_type code;
    rsb_abcd_type live [`RSB_NCHAN];
    rsb_abcd_type lag [`RSB_NCHAN];
    rsb_abcd_type prev [`RSB_NCHAN];
    logic [`RSB_NCHAN-1:0] deb;
    rsb_flags_type set;

    // superframe carries only A and B; C and D mirror them
    assign code = esf_i ? sig_abcd_i : {sig_abcd_i[3:2], sig_abcd_i[3:2]};

    genvar ch;
    generate
        for (ch = 0; ch < `RSB_NCHAN; ch++) begin : g_ch
            logic hit;
            logic steady;
            assign hit = sig_valid_i && (sig_chan_i == 5'(ch));
            assign steady = !(per_channel_enable_i && deb[ch]) || (code == prev[ch]);
            assign set[ch] = hit && steady && (code != live[ch]);
            always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    prev[ch] <= 4'h0;
                    live[ch] <= 4'h0;
                    lag[ch] <= 4'h0;
                    deb[ch] <= 1'b0;
                    flags_o[ch] <= 1'b0;
                end else begin
                    if (hit) begin
                        prev[ch] <= code;
                    end
                    if (set[ch]) begin
                        live[ch] <= code;
                    end
                    // lagged bank trails by at most one tick period
                    if (lag_tick_i) begin
                        lag[ch] <= live[ch];
                    end
                    if (cfg_we_i && cfg_chan_i == 5'(ch)) begin
                        deb[ch] <= cfg_deb_i;
                    end
                    // a new change wins over a read clear
                    if (set[ch]) begin
                        flags_o[ch] <= 1'b1;
                    end else if (clr_en_i && clr_mask_i[ch]) begin
                        flags_o[ch] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign change_o = |set;
    assign rd_live_o = live[rd_chan_i];
    assign rd_lag_o = lag[rd_chan_i];
    assign rd_deb_o = deb[rd_chan_i];
endmodule : rsb_chan_store

/* logic/rsb_rx_signaling_buffer.sv */
/*
 * Receive signaling buffer register bank: Avalon-MM slave, view
 * select, busy-guarded indirect access, change flags and interrupt.
 * Assumes an Avalon-MM master on ref_clk_i and a framer that posts
 * one channel's received signaling per sig_valid_i pulse.
 */
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "rsb_consts.svh"

module rsb_rx_signaling_buffer #(
    parameter int unsigned LAG_CYCLES = `RSB_LAG_CYC
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic sig_valid_i,
    input wire rsb_pkg::rsb_chan_type sig_chan_i,
    input wire rsb_pkg::rsb_abcd_type sig_abcd_i,
    output logic irq_o
);
    import rsb_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] cfg;
    logic [7:0] addr_ctrl;
    logic [7:0] data_buf;
    logic [1:0] irq_sts;
    logic [1:0] irq_en;
    logic rd_pend;
    logic [7:0] rd_byte;
    rsb_flags_type clr_mask;
    logic clr_en;
    rsb_ind_state_type state;
    logic [6:0] cnt;
    logic busy;
    logic [31:0] lag_cnt;
    logic lag_tick;
    logic [9:0] idx;
    logic wr_ok;
    logic view;
    logic ind_start;
    logic ind_done;
    logic [6:0] ind_addr;
    logic in_live;
    logic in_lag;
    logic in_deb;
    rsb_chan_type ind_chan;
    logic [7:0] ind_rdata;
    logic cfg_we;
    rsb_flags_type flags;
    logic change;
    rsb_abcd_type rd_live;
    rsb_abcd_type rd_lag;
    logic rd_deb;
    logic [7:0] next_rd_byte;
    rsb_flags_type next_clr_mask;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign idx = avs_address_i[11:2];
    // the bank data sits in byte lane 0 only
    assign wr_ok = avs_write_i && avs_byteenable_i[0];
    assign view = cfg[`RSB_CFG_VIEW];
    assign busy = (state == ind_run);
    // reads wait one cycle so the read data come from a flop
    assign avs_waitrequest_o = avs_read_i && !rd_pend;

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg <= `RSB_CFG_RST;
        end else if (wr_ok && idx == `RSB_IDX_CFG) begin
            if (view) begin
                // in flag view only the view bit is writable
                cfg[`RSB_CFG_VIEW] <= avs_writedata_i[`RSB_CFG_VIEW];
            end else begin
                cfg <= avs_writedata_i[7:0] & `RSB_CFG_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // indirect access engine
    // ------------------------------------------------------------
    // a launch while busy is dropped, the running access is unharmed
    assign ind_start = wr_ok && !view && !busy && idx == `RSB_IDX_ADDR;
    assign ind_done = busy && cnt == 7'(`RSB_BUSY_CYC - 1);
    assign ind_addr = addr_ctrl[6:0];
    assign in_live = ind_addr >= `RSB_LIVE_LO && ind_addr <= `RSB_LIVE_HI;
    assign in_lag = ind_addr >= `RSB_LAG_LO && ind_addr <= `RSB_LAG_HI;
    assign in_deb = ind_addr >= `RSB_DEB_LO && ind_addr <= `RSB_DEB_HI;

    always_comb begin
        ind_chan = 5'h00;
        if (in_live) begin
            ind_chan = 5'(ind_addr - `RSB_LIVE_LO);
        end else if (in_lag) begin
            ind_chan = 5'(ind_addr - `RSB_LAG_LO);
        end else if (in_deb) begin
            ind_chan = 5'(ind_addr - `RSB_DEB_LO);
        end
    end

    always_comb begin
        ind_rdata = 8'h00;
        if (in_live) begin
            ind_rdata = {4'h0, rd_live};
        end else if (in_lag) begin
            ind_rdata = {4'h0, rd_lag};
        end else if (in_deb) begin
            ind_rdata = {7'h00, rd_deb};
        end
    end

    // only the debounce entries take indirect writes; banks are read-only
    assign cfg_we = ind_done && !addr_ctrl[`RSB_RNW_BIT] && in_deb;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ind_idle;
            cnt <= 7'h00;
        end else begin
            case (state)
                ind_idle: begin
                    if (ind_start) begin
                        state <= ind_run;
                        cnt <= 7'h00;
                    end
                end
                ind_run: begin
                    if (ind_done) begin
                        state <= ind_idle;
                    end
                    cnt <= cnt + 7'h01;
                end
                default: begin
                    state <= ind_idle;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_ctrl <= `RSB_ADDR_RST;
        end else if (ind_start) begin
            addr_ctrl <= avs_writedata_i[7:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_buf <= `RSB_DATA_RST;
        end else if (busy && addr_ctrl[`RSB_RNW_BIT]
                && cnt == 7'(`RSB_RDATA_CYC - 1)) begin
            data_buf <= ind_rdata;
        end else if (wr_ok && !view && !busy && idx == `RSB_IDX_DATA) begin
            data_buf <= avs_writedata_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // lag tick for the second bank
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lag_cnt <= 32'h0;
        end else if (lag_cnt >= LAG_CYCLES - 1) begin
            lag_cnt <= 32'h0;
        end else begin
            lag_cnt <= lag_cnt + 32'h1;
        end
    end
    assign lag_tick = (lag_cnt >= LAG_CYCLES - 1);

    // ------------------------------------------------------------
    // channel store
    // ------------------------------------------------------------
    rsb_chan_store u_store (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .sig_valid_i(sig_valid_i),
        .sig_chan_i(sig_chan_i),
        .sig_abcd_i(sig_abcd_i),
        .esf_i(cfg[`RSB_CFG_ESF]),
        .per_channel_enable_i(cfg[`RSB_CFG_PER_CHANNEL_ENABLE]),
        .lag_tick_i(lag_tick),
        .cfg_we_i(cfg_we),
        .cfg_chan_i(ind_chan),
        .cfg_deb_i(data_buf[0]),
        .clr_en_i(clr_en),
        .clr_mask_i(clr_mask),
        .rd_chan_i(ind_chan),
        .flags_o(flags),
        .change_o(change),
        .rd_live_o(rd_live),
        .rd_lag_o(rd_lag),
        .rd_deb_o(rd_deb)
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        next_rd_byte = 8'h00;
        next_clr_mask = 24'h0;
        case (idx)
            `RSB_IDX_CFG: begin
                next_rd_byte = view ? (cfg & 8'h40) : cfg;
            end
            `RSB_IDX_STAT: begin
                if (view) begin
                    next_rd_byte = flags[23:16];
                    next_clr_mask = {flags[23:16], 16'h0};
                end else begin
                    next_rd_byte = {busy, 7'h00};
                end
            end
            `RSB_IDX_ADDR: begin
                if (view) begin
                    next_rd_byte = flags[15:8];
                    next_clr_mask = {8'h0, flags[15:8], 8'h0};
                end else begin
                    next_rd_byte = addr_ctrl;
                end
            end
            `RSB_IDX_DATA: begin
                if (view) begin
                    next_rd_byte = flags[7:0];
                    next_clr_mask = {16'h0, flags[7:0]};
                end else begin
                    next_rd_byte = data_buf;
                end
            end
            `RSB_IDX_ISTS: begin
                next_rd_byte = {6'h00, irq_sts};
            end
            `RSB_IDX_IEN: begin
                next_rd_byte = {6'h00, irq_en};
            end
            default: begin
                next_rd_byte = 8'h00;
            end
        endcase
    end

    // capture on the waiting cycle, answer on the next
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_pend <= 1'b0;
            rd_byte <= 8'h00;
            clr_mask <= 24'h0;
        end else if (avs_read_i && !rd_pend) begin
            rd_pend <= 1'b1;
            rd_byte <= next_rd_byte;
            clr_mask <= next_clr_mask;
        end else begin
            rd_pend <= 1'b0;
        end
    end
    assign avs_readdata_o = {24'h0, rd_byte};
    // only bits the master actually saw are cleared
    assign clr_en = avs_read_i && rd_pend;

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_en <= 2'h0;
        end else if (wr_ok && idx == `RSB_IDX_IEN) begin
            irq_en <= avs_writedata_i[1:0];
        end
    end

    // events win over a clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_sts <= 2'h0;
        end else begin
            irq_sts[0] <= change || (irq_sts[0]
                && !(wr_ok && idx == `RSB_IDX_ICLR && avs_writedata_i[0]));
            irq_sts[1] <= ind_done || (irq_sts[1]
                && !(wr_ok && idx == `RSB_IDX_ICLR && avs_writedata_i[1]));
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (|(irq_sts & irq_en))
                || (cfg[`RSB_CFG_SIGNAL_CHANGE_IRQ_EN] && (|flags));
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence ind_launch_s;
        ind_start;
    endsequence

    sequence busy_window_s;
        ##81 busy ##1 !busy;
    endsequence

    busy_length_a: assert property ($rose(busy) |-> busy_window_s)
        else $error("busy does not last 82 cycles");

    launch_takes_a: assert property (ind_launch_s |=> busy
            && addr_ctrl == $past(avs_writedata_i[7:0]))
        else $error("indirect launch not taken");

    busy_guard_a: assert property (wr_ok && busy
            && idx == `RSB_IDX_ADDR |=> $stable(addr_ctrl) && busy)
        else $error("address changed during busy");

    read_data_a: assert property ($rose(busy) && addr_ctrl[7]
            |-> ##79 1'b1 ##1 data_buf == $past(ind_rdata))
        else $error("indirect read data late or wrong");

    flag_view_a: assert property (avs_read_i && !rd_pend && view
            && idx == `RSB_IDX_STAT |=> avs_readdata_o[7:0] == $past(flags[23:16]))
        else $error("change flags not mapped in flag view");

    flag_clear_a: assert property (clr_en && !change
            |=> (flags & $past(clr_mask)) == 24'h0)
        else $error("read did not clear change flags");

    flag_set_a: assert property (change |=> |flags)
        else $error("change did not set a flag");

    irq_hold_a: assert property (cfg[5] && (|flags) |=> irq_o)
        else $error("interrupt missing with flags set");

    irq_quiet_a: assert property (!cfg[5] && (irq_sts & irq_en) == 2'h0
            |=> !irq_o)
        else $error("interrupt raised while disabled");

    lag_bound_a: assert property (lag_cnt < LAG_CYCLES)
        else $error("lag counter beyond bound");
endmodule : rsb_rx_signaling_buffer

/* sim/rsb_bus_master.sv */
/*
 * Avalon-MM master model of the processor that reaches the signaling buffer.
 * Assumes a slave on the same clock that answers by lowering waitrequest.
 */
`timescale 1ns/100ps

module rsb_bus_master (
    input wire logic ref_clk_i,
    output logic [11:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [31:0] avs_writedata_o,
    output logic [3:0] avs_byteenable_o,
    input wire logic [31:0] avs_readdata_i,
    input wire logic avs_waitrequest_i
);
    // ------------------------------------------------------------
    // one transfer: request held until waitrequest is seen low
    // ------------------------------------------------------------
    initial begin
        avs_address_o = 12'h000;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = 32'h0000_0000;
        avs_byteenable_o = 4'h0;
    end

    // waitrequest is sampled at rising edges only; the accept edge is the one
    // at which it is seen low, and only the bench watchdog ends a hang
    task automatic xfer(input logic [11:0] a, input logic rnw, input logic [7:0] wd,
                        input logic [3:0] be, output logic [7:0] rdv);
        @(posedge ref_clk_i);
        avs_address_o <= a;
        avs_read_o <= rnw;
        avs_write_o <= !rnw;
        avs_writedata_o <= {24'h00_0000, wd};
        avs_byteenable_o <= be;
        do begin
            @(posedge ref_clk_i);
        end while (avs_waitrequest_i !== 1'b0);
        rdv = avs_readdata_i[7:0];
        avs_read_o <= 1'b0;
        avs_write_o <= 1'b0;
    endtask : xfer
endmodule : rsb_bus_master

/* sim/rsb_rx_signaling_buffer_bench.sv */
/*
 * Self-checking bench of the receive signaling buffer register bank.
 * Assumes the bus master model and a shortened lag period of 16 cycles.
 */
`timescale 1ns/100ps
`include "rsb_consts.svh"

module rsb_rx_signaling_buffer_bench;
    import rsb_pkg::*;
    // ------------------------------------------------------------
    // clock, reset and wiring
    // ------------------------------------------------------------
    localparam logic [11:0] a_cfg = 12'h100;
    localparam logic [11:0] a_stat = 12'h104;
    localparam logic [11:0] a_iadr = 12'h108;
    localparam logic [11:0] a_idat = 12'h10c;
    localparam logic [11:0] a_ists = 12'h120;
    localparam logic [11:0] a_ien = 12'h124;
    localparam logic [11:0] a_iclr = 12'h128;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] address;
    logic rd_s, wr_s, wait_s, irq;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic sig_valid = 1'b0;
    rsb_chan_type sig_chan = 5'h00;
    rsb_abcd_type sig_abcd = 4'h0;
    int n_fail = 0;
    int n_compared = 0;
    logic [7:0] d;

    always #4 ref_clk = ~ref_clk;

    rsb_rx_signaling_buffer #(.LAG_CYCLES(16)) i_rsb_rx_signaling_buffer (
        .ref_clk_i(ref_clk), .reset_n_i(reset_n), .avs_address_i(address),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s),
        .sig_valid_i(sig_valid), .sig_chan_i(sig_chan), .sig_abcd_i(sig_abcd), .irq_o(irq));

    rsb_bus_master i_rsb_bus_master (
        .ref_clk_i(ref_clk), .avs_address_o(address), .avs_read_o(rd_s), .avs_write_o(wr_s),
        .avs_writedata_o(wdata), .avs_byteenable_o(be), .avs_readdata_i(rdata),
        .avs_waitrequest_i(wait_s));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        i_rsb_bus_master.xfer(a, 1'b1, 8'h00, 4'hf, d);
        chk(d, exp);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        i_rsb_bus_master.xfer(a, 1'b0, v, 4'hf, d);
    endtask : wr

    task automatic post(input int ch, input logic [3:0] v);
        @(posedge ref_clk);
        sig_valid <= 1'b1;
        sig_chan <= rsb_chan_type'(ch - 1);
        sig_abcd <= v;
        @(posedge ref_clk);
        sig_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : post

    task automatic irq_is(input logic exp);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({7'h00, irq}, {7'h00, exp});
    endtask : irq_is

    // launch an indirect access and poll busy until it drops
    task automatic ind(input logic [7:0] ac);
        int k;
        int cyc;
        realtime t0;
        wr(a_iadr, ac);
        t0 = $realtime;
        rd(a_stat, 8'h80);
        k = 0;
        d = 8'h80;
        while (d[7] !== 1'b0 && k < 60) begin
            i_rsb_bus_master.xfer(a_stat, 1'b1, 8'h00, 4'hf, d);
            k++;
        end
        cyc = int'(($realtime - t0) / 8.0);
        chk(d, 8'h00);
        chk({7'h00, cyc >= `RSB_BUSY_CYC && cyc <= `RSB_BUSY_CYC + 8}, 8'h01);
    endtask : ind

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #(8 * 20000);
        n_fail++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(a_cfg, 8'h00);
        rd(a_iadr, 8'h00);
        rd(12'h3fc, 8'h00);
        wr(a_cfg, 8'hff);
        rd(a_cfg, 8'h40);
        wr(a_cfg, 8'h00);
        rd(a_cfg, 8'h25);
        wr(a_cfg, 8'h04);
        post(5, 4'ha);
        ind(8'h85);
        rd(a_idat, 8'h0a);
        ind(8'h25);
        rd(a_idat, 8'h0a);
        ind(8'h99);
        rd(a_idat, 8'h00);
        // launch and data writes while busy must be dropped
        wr(a_iadr, 8'h85);
        wr(a_iadr, 8'h82);
        wr(a_idat, 8'h33);
        repeat (90) @(posedge ref_clk);
        rd(a_iadr, 8'h85);
        rd(a_idat, 8'h0a);
        wr(a_cfg, 8'h00);
        post(2, 4'b0111);
        ind(8'h82);
        rd(a_idat, 8'h05);
        wr(a_cfg, 8'h05);
        wr(a_idat, 8'h01);
        ind(8'h41);
        ind(8'hc1);
        rd(a_idat, 8'h01);
        post(1, 4'h5);
        ind(8'h81);
        rd(a_idat, 8'h00);
        post(1, 4'h5);
        ind(8'h81);
        rd(a_idat, 8'h05);
        wr(a_cfg, 8'h04);
        post(1, 4'h3);
        ind(8'h81);
        rd(a_idat, 8'h03);
        post(24, 4'h1);
        post(16, 4'h2);
        wr(a_cfg, 8'h64);
        irq_is(1'b1);
        rd(a_cfg, 8'h40);
        rd(a_stat, 8'h80);
        rd(a_stat, 8'h00);
        rd(a_iadr, 8'h80);
        rd(a_idat, 8'h13);
        irq_is(1'b0);
        post(9, 4'h4);
        irq_is(1'b1);
        rd(a_iadr, 8'h01);
        irq_is(1'b0);
        wr(a_cfg, 8'h00);
        wr(a_cfg, 8'h44);
        post(17, 4'h8);
        irq_is(1'b0);
        rd(a_stat, 8'h01);
        rd(a_ists, 8'h03);
        i_rsb_bus_master.xfer(a_ien, 1'b0, 8'h01, 4'h0, d);
        irq_is(1'b0);
        wr(a_ien, 8'h01);
        irq_is(1'b1);
        wr(a_iclr, 8'h01);
        irq_is(1'b0);
        rd(a_ists, 8'h02);
        final_report();
    end
endmodule : rsb_rx_signaling_buffer_bench
